// File: verilog/prthi_top.sv
// Proximity result, threshold and interrupt register block
// Functional notes
// [RQ1] Latest proximity reading: upper byte at 87h, lower byte at 88h.
// [RQ2] Upper result register is read-only, bits 15:8, writes ignored.
// [RQ3] Lower result register is read-only, bits 7:0, writes ignored.
// [RQ4] Threshold event after 1..128 consecutive beyond-threshold samples, power-of-two code.
// [RQ5] Count field resets to 000, a single sample qualifies.
// [RQ6] Count code 110 means 64 consecutive samples.
// [RQ7] One select bit applies thresholds to proximity or ambient results.
// [RQ8] Three enables gate proximity ready, ambient ready and threshold interrupts.
// [RQ9] Low threshold 16 bits: upper byte 8Ah, lower byte 8Bh.
// [RQ10] Upper low-threshold register is read/write, bits 15:8.
// [RQ11] Lower low-threshold register is read/write, bits 7:0.
// [RQ12] High threshold 16 bits: upper byte 8Ch, lower byte 8Dh.
// [RQ13] Upper high-threshold register is read/write, bits 15:8.
// [RQ14] Lower high-threshold register is read/write, bits 7:0.
// [RQ15] Above high threshold is a high crossing; below low is a low crossing.
// [RQ16] Status at 8Eh holds four flags: prox ready, als ready, low, high.
// [RQ17] Flags set and hold; host clears by writing one.
// [RQ18] Interrupt pin low while any status flag is set.
`timescale 1ns/1ps
module prthi_top (
  input wire logic mclk,                 // System clock, 100 MHz
  input wire logic rstn,                 // Synchronous reset, active low
  input wire prthi_pkg::prthi_bus_t bus, // Register access from the serial host interface
  input wire prthi_pkg::prthi_meas_t meas, // Measurement results and strobes
  output logic [7:0] rdata,              // Read data, valid the cycle after rdEn
  output logic irqn                      // Interrupt pin, active low
);

  // ==========================================================
  // Storage
  logic [15:0] proxResult;
  logic [15:0] lowThresh;
  logic [15:0] highThresh;
  logic [7:0] irqCtrl;
  logic [3:0] status;
  logic [7:0] countTarget;
  logic [15:0] cmpValue;
  logic cmpStrobe;
  logic floorHit;
  logic ceilHit;
  logic [3:0] setMask;
  logic [3:0] clrMask;
  logic [7:0] next_rdata;
  logic [3:0] next_status;
  logic [3:0] flagEvent;
  logic [3:0] flagEnable;
  logic wrCtrl;
  logic wrStatus;
  logic filterRstn;

  // ==========================================================
  // Write decode for registers whose writes have side effects
  assign wrCtrl = bus.wrEn && (bus.addr == prthi_pkg::ADDR_IRQ_CTRL); // Also restarts the filters
  assign wrStatus = bus.wrEn && (bus.addr == prthi_pkg::ADDR_IRQ_STATUS); // Write-one-to-clear

  // ==========================================================
  // Result capture, host writes never reach it
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      proxResult <= prthi_pkg::RST_RESULT;
    end else if (meas.proxReady) begin
      proxResult <= meas.proxData; // RQ1 RQ2 RQ3
    end
  end

  // ==========================================================
  // Interrupt control register: count code, enables, source select
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irqCtrl <= prthi_pkg::RST_CTRL; // RQ5
    end else if (wrCtrl) begin
      irqCtrl <= bus.wdata;
    end
  end

  // ==========================================================
  // Threshold registers
  // Low threshold, byte-wide halves written independently
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      lowThresh <= prthi_pkg::RST_THRESH;
    end else if (bus.wrEn && bus.addr == prthi_pkg::ADDR_LOWTH_HIGH) begin
      lowThresh[15:8] <= bus.wdata; // RQ9 RQ10
    end else if (bus.wrEn && bus.addr == prthi_pkg::ADDR_LOWTH_LOW) begin
      lowThresh[7:0] <= bus.wdata; // RQ11
    end
  end

  // High threshold, byte-wide halves written independently
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      highThresh <= prthi_pkg::RST_THRESH;
    end else if (bus.wrEn && bus.addr == prthi_pkg::ADDR_HIGHTH_HIGH) begin
      highThresh[15:8] <= bus.wdata; // RQ12 RQ13
    end else if (bus.wrEn && bus.addr == prthi_pkg::ADDR_HIGHTH_LOW) begin
      highThresh[7:0] <= bus.wdata; // RQ14
    end
  end

  // ==========================================================
  // Threshold comparison
  always_comb begin
    case (irqCtrl[7:prthi_pkg::CTRL_COUNT_LSB])
      3'h0: countTarget = 8'h01; // RQ4
      3'h1: countTarget = 8'h02;
      3'h2: countTarget = 8'h04;
      3'h3: countTarget = 8'h08;
      3'h4: countTarget = 8'h10;
      3'h5: countTarget = 8'h20;
      3'h6: countTarget = 8'h40; // RQ6
      default: countTarget = 8'h80;
    endcase
  end

  // Compared value follows the source select
  assign cmpValue = irqCtrl[prthi_pkg::CTRL_SRC_SEL_BIT] ? meas.alsData : meas.proxData; // RQ7
  // Only the selected path's strobe advances the filters
  assign cmpStrobe = irqCtrl[prthi_pkg::CTRL_SRC_SEL_BIT] ? meas.alsReady : meas.proxReady; // RQ7

  // Runs restart on a control write, so counts gathered under an old
  // source or count code never qualify an event under the new setting
  assign filterRstn = rstn && !wrCtrl;

  // ==========================================================
  // Consecutive-count filters, one per threshold direction
  // Low crossing filter
  prthi_filter floorFilter (
    .mclk(mclk),
    .rstn(filterRstn),
    .sample(cmpStrobe),
    .beyond(cmpValue < lowThresh), // RQ15
    .target(countTarget),
    .hit(floorHit)
  );

  // High crossing filter
  prthi_filter ceilFilter (
    .mclk(mclk),
    .rstn(filterRstn),
    .sample(cmpStrobe),
    .beyond(cmpValue > highThresh), // RQ15
    .target(countTarget),
    .hit(ceilHit)
  );

  // ==========================================================
  // Status flags: which event sets which bit
  always_comb begin
    flagEvent = 4'h0;
    flagEvent[prthi_pkg::STAT_PROX_BIT] = meas.proxReady;
    flagEvent[prthi_pkg::STAT_ALS_BIT] = meas.alsReady;
    flagEvent[prthi_pkg::STAT_FLOOR_BIT] = floorHit;
    flagEvent[prthi_pkg::STAT_CEIL_BIT] = ceilHit;
  end

  // Enable bit that gates each flag
  always_comb begin
    flagEnable = 4'h0;
    flagEnable[prthi_pkg::STAT_PROX_BIT] = irqCtrl[prthi_pkg::CTRL_PROX_EN_BIT];
    flagEnable[prthi_pkg::STAT_ALS_BIT] = irqCtrl[prthi_pkg::CTRL_ALS_EN_BIT];
    flagEnable[prthi_pkg::STAT_FLOOR_BIT] = irqCtrl[prthi_pkg::CTRL_LIMIT_EN_BIT];
    flagEnable[prthi_pkg::STAT_CEIL_BIT] = irqCtrl[prthi_pkg::CTRL_LIMIT_EN_BIT];
  end

  // Disabled sources never set a flag
  assign setMask = flagEvent & flagEnable; // RQ8

  // Writing one to a status bit clears it, zeros leave it alone
  assign clrMask = wrStatus ? bus.wdata[3:0] : 4'h0; // RQ17

  // Per-flag next state, an event in the clearing cycle keeps the flag set
  for (genvar i = 0; i < 4; i++) begin : gFlag
    assign next_status[i] = setMask[i] | (status[i] & ~clrMask[i]); // RQ17
  end

  // Flag register
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      status <= prthi_pkg::RST_STATUS;
    end else begin
      status <= next_status; // RQ16 RQ17
    end
  end

  // Interrupt pin follows the next flag state, so it moves with the flags
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irqn <= 1'b1;
    end else begin
      irqn <= ~|next_status; // RQ18
    end
  end

  // ==========================================================
  // Read mux
  always_comb begin
    case (bus.addr)
      prthi_pkg::ADDR_PROX_HIGH: next_rdata = proxResult[15:8]; // RQ2
      prthi_pkg::ADDR_PROX_LOW: next_rdata = proxResult[7:0]; // RQ3
      prthi_pkg::ADDR_IRQ_CTRL: next_rdata = irqCtrl;
      prthi_pkg::ADDR_LOWTH_HIGH: next_rdata = lowThresh[15:8]; // RQ10
      prthi_pkg::ADDR_LOWTH_LOW: next_rdata = lowThresh[7:0]; // RQ11
      prthi_pkg::ADDR_HIGHTH_HIGH: next_rdata = highThresh[15:8]; // RQ13
      prthi_pkg::ADDR_HIGHTH_LOW: next_rdata = highThresh[7:0]; // RQ14
      prthi_pkg::ADDR_IRQ_STATUS: next_rdata = {4'h0, status}; // RQ16
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data register, loads only on a read strobe
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (bus.rdEn) begin
      rdata <= next_rdata;
    end
  end

endmodule

// File: verilog/prthi_pkg.sv
// Package of constants and types for the proximity result and threshold interrupt block
package prthi_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [7:0] ADDR_PROX_HIGH = 8'h87;
  localparam logic [7:0] ADDR_PROX_LOW = 8'h88;
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h89;
  localparam logic [7:0] ADDR_LOWTH_HIGH = 8'h8A;
  localparam logic [7:0] ADDR_LOWTH_LOW = 8'h8B;
  localparam logic [7:0] ADDR_HIGHTH_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_HIGHTH_LOW = 8'h8D;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h8E;

  // ==========================================================
  // Interrupt control field positions
  localparam int CTRL_COUNT_LSB = 5;
  localparam int CTRL_PROX_EN_BIT = 3;
  localparam int CTRL_ALS_EN_BIT = 2;
  localparam int CTRL_LIMIT_EN_BIT = 1;
  localparam int CTRL_SRC_SEL_BIT = 0;

  // Interrupt status field positions
  localparam int STAT_PROX_BIT = 3;
  localparam int STAT_ALS_BIT = 2;
  localparam int STAT_FLOOR_BIT = 1;
  localparam int STAT_CEIL_BIT = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [15:0] RST_THRESH = 16'h0000;
  localparam logic [15:0] RST_RESULT = 16'h0000;
  localparam logic [3:0] RST_STATUS = 4'h0;
  localparam logic [7:0] RST_COUNT = 8'h00;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic wrEn;       // One-cycle write strobe
    logic rdEn;       // One-cycle read strobe
    logic [7:0] addr; // Register address
    logic [7:0] wdata; // Write data
  } prthi_bus_t;

  typedef struct packed {
    logic proxReady;  // Proximity result strobe
    logic alsReady;   // Ambient result strobe
    logic [15:0] proxData; // Proximity result
    logic [15:0] alsData;  // Ambient result
  } prthi_meas_t;

endpackage

// File: verilog/prthi_filter.sv
// Consecutive-count filter for one threshold direction
`timescale 1ns/1ps
module prthi_filter (
  input wire logic mclk,         // System clock
  input wire logic rstn,         // Synchronous reset, active low
  input wire logic sample,       // One-cycle measurement strobe
  input wire logic beyond,       // Sample lies beyond the threshold
  input wire logic [7:0] target, // Needed consecutive count
  output logic hit               // One-cycle qualified event
);

  logic [7:0] run;

  // Count consecutive samples beyond the threshold, fire on reaching the target
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      run <= prthi_pkg::RST_COUNT;
      hit <= 1'b0;
    end else begin
      hit <= 1'b0;
      if (sample) begin
        if (!beyond) begin
          run <= prthi_pkg::RST_COUNT;
        end else if (run + 8'h01 >= target) begin
          hit <= 1'b1; // RQ4
          run <= prthi_pkg::RST_COUNT;
        end else begin
          run <= run + 8'h01;
        end
      end
    end
  end

endmodule

// File: bench/prthi_chk.sv
// Checker of register reads and interrupt pin
`timescale 1ns/1ps
module prthi_chk (
  input wire logic mclk, // Clock
  input wire logic rstn, // Reset, low
  input wire prthi_pkg::prthi_bus_t bus, // Register access
  input wire prthi_pkg::prthi_meas_t meas, // Results
  input wire logic [7:0] rdata, // Read data
  input wire logic irqn // Interrupt, low
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ==========
  // Read path
  rd_hold_a: assert property (!bus.rdEn |=> $stable(rdata)) else $error("rdata moved");
  unmapped_zero_a: assert property (bus.rdEn && (bus.addr < 8'h87 || bus.addr > 8'h8E)
    |=> rdata == 8'h00) else $error("unmapped read");
  status_top_a: assert property (bus.rdEn && bus.addr == 8'h8E |=> rdata[7:4] == 4'h0)
    else $error("status top bits");
  prox_high_a: assert property (meas.proxReady ##1 (bus.rdEn && bus.addr == 8'h87)
    |=> {rdata, 8'h00} == ($past(meas.proxData, 2) & 16'hFF00)) else $error("result byte");
  thresh_rw_a: assert property (bus.rdEn && $past(bus.wrEn) && bus.addr == $past(bus.addr)
    && bus.addr inside {[8'h8A:8'h8D]} |=> rdata == $past(bus.wdata, 2)) else $error("thresh");
  // ==========
  // Interrupt pin
  irq_cause_a: assert property ($fell(irqn) |-> $past(meas.proxReady) || $past(meas.alsReady)
    || $past(meas.proxReady, 2) || $past(meas.alsReady, 2)) else $error("irq without cause");
  irq_release_a: assert property ($rose(irqn) |-> $past(bus.wrEn) && $past(bus.addr) == 8'h8E)
    else $error("irq released");
  irq_hold_a: assert property (!irqn && !(bus.wrEn && bus.addr == 8'h8E) |=> !irqn)
    else $error("irq dropped");
  cover property (!irqn);
  cover property ($rose(irqn));
  cover property (meas.alsReady ##2 !irqn);
endmodule
bind prthi_top prthi_chk u_chk (.mclk(mclk), .rstn(rstn), .bus(bus), .meas(meas),
  .rdata(rdata), .irqn(irqn));

// File: bench/prthi_host.sv
// Host model issuing register accesses
`timescale 1ns/1ps
module prthi_host (
  input wire logic mclk, // Clock
  input wire logic [7:0] rdata, // Read data
  output prthi_pkg::prthi_bus_t bus // Register access
);
  initial bus = '0;
  // One access; idle lines show the inverse so no stale value survives
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d, input logic last);
    bus = '{w, !w, a, d};
    @(posedge mclk);
    #1;
    if (last) begin
      bus = '{1'b0, 1'b0, ~a, ~d};
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(1'b1, a, d, 1'b1);
  endtask
  // One read; data is taken while it still stands after the idle cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    op(1'b0, a, 8'h00, 1'b1);
    d = rdata;
  endtask
endmodule

// File: bench/prthi_tb.sv
// Testbench of the result, threshold and interrupt block
`timescale 1ns/1ps
module tb;
  logic mclk;
  logic rstn;
  prthi_pkg::prthi_bus_t bus;
  prthi_pkg::prthi_meas_t meas;
  logic [7:0] rdata;
  logic irqn;
  int failures;
  int numChecks;
  int cyc;
  prthi_top u_dut (.mclk(mclk), .rstn(rstn), .bus(bus), .meas(meas), .rdata(rdata), .irqn(irqn));
  prthi_host u_host (.mclk(mclk), .rdata(rdata), .bus(bus));
  // ==========
  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      wrap_up;
    end
  end
  // ==========
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chki(input logic exp);
    numChecks++;
    if (irqn !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, irqn, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] got;
    u_host.rd(a, got);
    chk(got, exp);
  endtask
  // The path not selected carries the inverse, so a wrong source shows up
  task automatic ms(input logic als, input logic [15:0] v);
    meas = '{!als, als, als ? ~v : v, als ? v : ~v};
    @(posedge mclk);
    #1;
    meas = '{1'b0, 1'b0, ~v, ~v};
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    chki(1'b1);
    for (int a = 8'h86; a <= 8'h8F; a++) begin
      rdc(8'(a), 8'h00);
    end
  endtask
  task automatic t_regs;
    for (int i = 0; i < 4; i++) begin
      u_host.op(1'b1, 8'(8'h8A + i), 8'(8'hA5 + i), 1'b0);
      rdc(8'(8'h8A + i), 8'(8'hA5 + i));
    end
    u_host.wr(8'h87, 8'hFF);
    u_host.wr(8'h88, 8'hFF);
    rdc(8'h87, 8'h00);
    rdc(8'h88, 8'h00);
  endtask
  task automatic t_prox;
    u_host.wr(8'h89, 8'h08);
    ms(1'b0, 16'h1234);
    rdc(8'h87, 8'h12);
    rdc(8'h88, 8'h34);
    ms(1'b1, 16'h0000);
    rdc(8'h8E, 8'h08);
    chki(1'b0);
    u_host.wr(8'h8E, 8'h07);
    rdc(8'h8E, 8'h08);
    u_host.wr(8'h8E, 8'h08);
    chki(1'b1);
    u_host.wr(8'h89, 8'h04);
    ms(1'b1, 16'h0000);
    rdc(8'h8E, 8'h04);
    chki(1'b0);
    u_host.wr(8'h8E, 8'h04);
    chki(1'b1);
  endtask
  task automatic t_count;
    u_host.wr(8'h8A, 8'h01);
    u_host.wr(8'h8B, 8'h00);
    u_host.wr(8'h8C, 8'h02);
    u_host.wr(8'h8D, 8'h00);
    for (int c = 0; c < 8; c++) begin
      u_host.wr(8'h89, 8'((c << 5) | 8'h02 | c[0]));
      ms(c[0], c[0] ? 16'h0100 : 16'h0200);
      for (int j = 0; j < (1 << c); j++) begin
        @(posedge mclk);
        #1;
        chki(1'b1);
        ms(c[0], c[0] ? 16'h00FF : 16'h0201);
      end
      repeat (2) @(posedge mclk);
      #1;
      chki(1'b0);
      rdc(8'h8E, c[0] ? 8'h02 : 8'h01);
      u_host.wr(8'h8E, 8'h0F);
    end
  endtask
  initial begin
    rstn = 1'b0;
    meas = '0;
    repeat (8) @(posedge mclk);
    #1;
    rstn = 1'b1;
    t_reset;
    t_regs;
    t_prox;
    t_count;
    wrap_up;
  end
endmodule
